//--- common/pwg_pkg.sv
// Package for the key write guard and non-volatile byte staging block.
// Holds register offsets, reset values, widths and the refresh timing.
// Assumes an 8-bit register space with byte-wide data.

`default_nettype none

package pwg_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned PWG_ADDR_W = 8;
   localparam int unsigned PWG_DATA_W = 8;
   localparam int unsigned PWG_KEY_W  = 32;
   localparam int unsigned PWG_CNT_W  = 24;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PWG_OFS_KEY_BYTE0 = 8'h39;
   localparam logic [7:0] PWG_OFS_KEY_BYTE1 = 8'h3A;
   localparam logic [7:0] PWG_OFS_KEY_BYTE2 = 8'h3B;
   localparam logic [7:0] PWG_OFS_KEY_BYTE3 = 8'h3C;
   localparam logic [7:0] PWG_OFS_NV_INDEX  = 8'h3D;
   localparam logic [7:0] PWG_OFS_NV_VALUE  = 8'h3E;

   // ----------------------------------------------------------------
   // Values after reset and fixed codes
   // ----------------------------------------------------------------
   localparam logic [7:0] PWG_RST_KEY_BYTE = 8'h00;
   localparam logic [7:0] PWG_RST_NV_INDEX = 8'hC0;
   localparam logic [7:0] PWG_RST_NV_VALUE = 8'h00;
   localparam logic [7:0] PWG_READ_ZERO    = 8'h00;
   localparam logic [7:0] PWG_CHECK_ON     = 8'hFF;

   // ----------------------------------------------------------------
   // Timing: first configuration refresh after power-up
   // ----------------------------------------------------------------
   localparam int unsigned PWG_CLK_MHZ            = 200;
   localparam int unsigned PWG_FIRST_REFRESH_MS   = 66;
   localparam int unsigned PWG_FIRST_REFRESH_CYC  =
      PWG_FIRST_REFRESH_MS * 1000 * PWG_CLK_MHZ;

   // Power-up sequencing states, Gray coded
   typedef enum logic [1:0] {
      PWG_ST_WAIT  = 2'b00,
      PWG_ST_CLEAR = 2'b01,
      PWG_ST_RUN   = 2'b11
   } pwg_state_t;

endpackage

`default_nettype wire

//--- core/pwg_byte_reg.sv
// One byte-wide register with a fixed value after reset.
// Assumes a synchronous active-high reset and a shared clock enable.

`timescale 1ns/1ps
`default_nettype none

module pwg_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_clk_en,
   input  wire logic       i_load,
   input  wire logic [7:0] i_data,
   output logic      [7:0] o_value
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Load wins only while the clock enable is high
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_value <= RESET_VALUE;
      end else if (i_clk_en && i_load) begin
         o_value <= i_data;
      end
   end

endmodule

`default_nettype wire

//--- core/pwg_guard.sv
// Key write guard and non-volatile byte staging registers.
// Assumes register requests come from bus logic on the same clock,
// the stored key mirror and enable setting arrive from the config RAM,
// and the transfer engine loads read results on i_nv_read_load.
//
// How it works
// - Clear entered key after first refresh time
// - Check active only when enable equals 255
// - Guard every guarded-class register write
// - Compare all 32 key bits with mirror
// - Key bytes at 39h through 3Ch, LSB first
// - Key bytes write only, read zero
// - Index register, 8 bits, resets C0h
// - Value register, 8 bits, resets 00h
// - Index and value readable, writes guarded

`timescale 1ns/1ps
`default_nettype none

module pwg_guard
   import pwg_pkg::*;
#(
   parameter int unsigned FIRST_REFRESH_CYC = PWG_FIRST_REFRESH_CYC
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   input  wire logic                  i_clk_en,
   input  wire logic [PWG_ADDR_W-1:0] i_reg_addr,
   input  wire logic [PWG_DATA_W-1:0] i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   input  wire logic                  i_wr_guarded,
   input  wire logic [PWG_KEY_W-1:0]  i_stored_key,
   input  wire logic [7:0]            i_key_check_enable,
   input  wire logic                  i_nv_read_load,
   input  wire logic [PWG_DATA_W-1:0] i_nv_read_data,
   output logic      [PWG_DATA_W-1:0] o_reg_rdata,
   output logic                       o_reg_rvalid,
   output logic                       o_fwd_wr,
   output logic      [PWG_ADDR_W-1:0] o_fwd_addr,
   output logic      [PWG_DATA_W-1:0] o_fwd_wdata,
   output logic                       o_write_open,
   output logic                       o_refresh_done,
   output logic      [PWG_DATA_W-1:0] o_nv_byte_index,
   output logic      [PWG_DATA_W-1:0] o_nv_byte_value
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [PWG_CNT_W-1:0] REFRESH_LAST =
      PWG_CNT_W'(FIRST_REFRESH_CYC - 1);

   pwg_state_t             state;
   pwg_state_t             next_state;
   logic [PWG_CNT_W-1:0]   refresh_count;
   logic [PWG_KEY_W-1:0]   entered_key;
   logic [7:0]             key_byte [4];
   logic [3:0]             key_hit;
   logic [3:0]             key_load;
   logic [7:0]             key_data;
   logic                   wr_take;
   logic                   rd_take;
   logic                   check_active;
   logic                   key_match;
   logic                   write_open;
   logic                   hit_index;
   logic                   hit_value;
   logic                   hit_local;
   logic                   own_guarded;
   logic                   index_load;
   logic                   value_load;
   logic [7:0]             value_data;
   logic                   fwd_take;
   logic [7:0]             rd_mux;
   logic                   clear_keys;

   // ----------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------
   // Requests count only while the clock enable is high
   assign wr_take = i_clk_en & i_reg_wr;
   assign rd_take = i_clk_en & i_reg_rd;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // One hit per key byte, consecutive offsets
   assign key_hit[0] = (i_reg_addr == PWG_OFS_KEY_BYTE0);
   assign key_hit[1] = (i_reg_addr == PWG_OFS_KEY_BYTE1);
   assign key_hit[2] = (i_reg_addr == PWG_OFS_KEY_BYTE2);
   assign key_hit[3] = (i_reg_addr == PWG_OFS_KEY_BYTE3);
   assign hit_index  = (i_reg_addr == PWG_OFS_NV_INDEX);
   assign hit_value  = (i_reg_addr == PWG_OFS_NV_VALUE);
   assign hit_local  = (|key_hit) | hit_index | hit_value;

   // Own registers of the guarded class
   assign own_guarded = hit_index | hit_value;

   // ----------------------------------------------------------------
   // Key check
   // ----------------------------------------------------------------
   // Guard only armed at the one enable code
   assign check_active = (i_key_check_enable == PWG_CHECK_ON);

   // Full-width compare against the RAM mirror
   assign key_match = (entered_key == i_stored_key);

   // Writes pass when disarmed or the key matches
   assign write_open = ~check_active | key_match;

   // ----------------------------------------------------------------
   // Power-up refresh sequencing
   // ----------------------------------------------------------------
   // Wait out the first refresh, clear once, then run
   always_comb begin
      next_state = state;
      unique case (state)
         PWG_ST_WAIT: begin
            if (refresh_count == REFRESH_LAST) begin
               next_state = PWG_ST_CLEAR;
            end
         end
         PWG_ST_CLEAR: begin
            next_state = PWG_ST_RUN;
         end
         PWG_ST_RUN: begin
            next_state = PWG_ST_RUN;
         end
         default: begin
            next_state = PWG_ST_WAIT;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= PWG_ST_WAIT;
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   // Refresh timer, counts only while waiting
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         refresh_count <= '0;
      end else if (i_clk_en && state == PWG_ST_WAIT) begin
         refresh_count <= refresh_count + PWG_CNT_W'(1);
      end
   end

   // Clear pulse at end of the first refresh
   assign clear_keys = (state == PWG_ST_CLEAR);

   // ----------------------------------------------------------------
   // Entered key bytes
   // ----------------------------------------------------------------
   // Clear overrides a host write in the same cycle
   assign key_load = clear_keys ? 4'hF : (key_hit & {4{i_reg_wr}});
   assign key_data = clear_keys ? PWG_RST_KEY_BYTE : i_reg_wdata;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_key
         pwg_byte_reg #(
            .RESET_VALUE (PWG_RST_KEY_BYTE)
         ) u_key_byte (
            .i_clock  (i_clock),
            .i_rst    (i_rst),
            .i_clk_en (i_clk_en),
            .i_load   (key_load[gi]),
            .i_data   (key_data),
            .o_value  (key_byte[gi])
         );
         // Byte gi holds key bits 8*gi+7 down to 8*gi
         assign entered_key[8*gi +: 8] = key_byte[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Non-volatile byte index and value
   // ----------------------------------------------------------------
   // Index write only when the guard is open
   assign index_load = wr_take & hit_index & write_open;

   pwg_byte_reg #(
      .RESET_VALUE (PWG_RST_NV_INDEX)
   ) u_nv_index (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_clk_en (i_clk_en),
      .i_load   (index_load),
      .i_data   (i_reg_wdata),
      .o_value  (o_nv_byte_index)
   );

   // Engine read result wins over a host write
   assign value_load = i_nv_read_load | (i_reg_wr & hit_value & write_open);
   assign value_data = i_nv_read_load ? i_nv_read_data : i_reg_wdata;

   pwg_byte_reg #(
      .RESET_VALUE (PWG_RST_NV_VALUE)
   ) u_nv_value (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_clk_en (i_clk_en),
      .i_load   (value_load),
      .i_data   (value_data),
      .o_value  (o_nv_byte_value)
   );

   // ----------------------------------------------------------------
   // Forwarding of guarded writes elsewhere
   // ----------------------------------------------------------------
   // Outside writes pass unless guarded and locked
   assign fwd_take = wr_take & ~hit_local & (~i_wr_guarded | write_open);

   // Forwarded strobe with its address and data
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_fwd_wr    <= 1'b0;
         o_fwd_addr  <= '0;
         o_fwd_wdata <= '0;
      end else if (i_clk_en) begin
         o_fwd_wr <= fwd_take;
         if (fwd_take) begin
            o_fwd_addr  <= i_reg_addr;
            o_fwd_wdata <= i_reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Key bytes and unmapped offsets read zero
   assign rd_mux = hit_index ? o_nv_byte_index :
                   hit_value ? o_nv_byte_value :
                   PWG_READ_ZERO;

   // Read data registered one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata  <= PWG_READ_ZERO;
         o_reg_rvalid <= 1'b0;
      end else if (i_clk_en) begin
         o_reg_rvalid <= rd_take;
         if (rd_take) begin
            o_reg_rdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   // Guard state and refresh completion for the rest of the chip
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_write_open   <= 1'b0;
         o_refresh_done <= 1'b0;
      end else if (i_clk_en) begin
         o_write_open   <= write_open;
         o_refresh_done <= (state == PWG_ST_RUN);
      end
   end

endmodule

`default_nettype wire

//--- sim/pwg_guard_chk.sv
// Port assertions for the key write guard block.
// Assumes binding to every pwg_guard instance on its own clock.
`timescale 1ns/1ps
`default_nettype none
module pwg_guard_chk
   import pwg_pkg::*;
(
   input wire logic       i_clock,
   input wire logic       i_rst,
   input wire logic       i_clk_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic       i_wr_guarded,
   input wire logic [7:0] i_key_check_enable,
   input wire logic       i_nv_read_load,
   input wire logic [7:0] i_nv_read_data,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   input wire logic       o_fwd_wr,
   input wire logic [7:0] o_fwd_addr,
   input wire logic       o_write_open,
   input wire logic [7:0] o_nv_byte_index,
   input wire logic [7:0] o_nv_byte_value
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Address classes
   wire key_hit = i_reg_addr >= 8'h39 && i_reg_addr <= 8'h3C;
   wire own_hit = i_reg_addr >= 8'h39 && i_reg_addr <= 8'h3E;
   wire wr_go   = i_clk_en && i_reg_wr;
   a_read_valid: assert property (i_clk_en && i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
   a_key_reads_zero: assert property (i_clk_en && i_reg_rd && key_hit |=> o_reg_rdata == 8'h00)
      else $error("key byte read not zero");
   a_open_unchecked: assert property ($past(i_clk_en) && !$past(i_rst)
      && $past(i_key_check_enable) != 8'hFF |-> o_write_open)
      else $error("guard closed with check off");
   a_index_free: assert property (wr_go && i_reg_addr == 8'h3D && i_key_check_enable != 8'hFF
      |=> o_nv_byte_index == $past(i_reg_wdata))
      else $error("index write lost");
   a_index_cause: assert property (!$past(i_rst) && o_nv_byte_index != $past(o_nv_byte_index)
      |-> $past(wr_go) && $past(i_reg_addr) == 8'h3D)
      else $error("index changed without write");
   a_value_load: assert property (i_clk_en && i_nv_read_load
      |=> o_nv_byte_value == $past(i_nv_read_data))
      else $error("value load lost");
   a_fwd_outside: assert property (wr_go && !i_wr_guarded && !own_hit
      |=> o_fwd_wr && o_fwd_addr == $past(i_reg_addr))
      else $error("open write not forwarded");
   a_no_fwd_own: assert property (wr_go && own_hit |=> !o_fwd_wr)
      else $error("own register forwarded");
endmodule
bind pwg_guard pwg_guard_chk u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_wr_guarded(i_wr_guarded), .i_key_check_enable(i_key_check_enable),
   .i_nv_read_load(i_nv_read_load), .i_nv_read_data(i_nv_read_data),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_fwd_wr(o_fwd_wr),
   .o_fwd_addr(o_fwd_addr), .o_write_open(o_write_open),
   .o_nv_byte_index(o_nv_byte_index), .o_nv_byte_value(o_nv_byte_value));
`default_nettype wire

//--- sim/pwg_host.sv
// Host controller model issuing one-cycle register requests.
// Assumes requests are taken on the next rising edge.
`timescale 1ns/1ps
`default_nettype none
module pwg_host (
   input  wire logic       i_clock,
   output var  logic [7:0] o_addr,
   output var  logic [7:0] o_wdata,
   output var  logic       o_wr,
   output var  logic       o_rd
);
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // One request, held to its taking edge, bus inverted after
   task automatic xfer(input logic [7:0] a, d, input logic w);
      @(posedge i_clock);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= w;
      o_rd    <= !w;
      @(posedge i_clock);
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask
endmodule
`default_nettype wire

//--- sim/test_password_write_guard_nv_access.sv
// Self-checking bench for the key write guard block.
// Assumes the host model drives the register requests.
`timescale 1ns/1ps
`default_nettype none
module test_password_write_guard_nv_access;
   import pwg_pkg::*;
   logic       i_clock = 1'b0;
   logic       i_rst = 1'b1;
   logic       i_wr_guarded = 1'b0;
   logic [31:0] skey = 32'h0;
   logic [7:0] kce = 8'hFF;
   logic       ld = 1'b0;
   logic [7:0] ldd = 8'h00;
   logic [7:0] addr, wdata, rdata, d;
   logic       wr, rd, rvalid, fwd, done;
   logic [7:0] expq[$];
   logic [7:0] fwdq[$];
   logic [7:0] faddr, fdata;
   logic       ce = 1'b1;
   int         bad_count, check_count, fwd_n, n;
   initial forever #2.5 i_clock = ~i_clock;
   pwg_host H (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   pwg_guard #(.FIRST_REFRESH_CYC(40)) DUT (.i_clock(i_clock), .i_rst(i_rst),
      .i_clk_en(ce), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_wr_guarded(i_wr_guarded), .i_stored_key(skey),
      .i_key_check_enable(kce), .i_nv_read_load(ld), .i_nv_read_data(ldd),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_fwd_wr(fwd), .o_fwd_addr(faddr),
      .o_fwd_wdata(fdata), .o_write_open(), .o_refresh_done(done), .o_nv_byte_index(),
      .o_nv_byte_value());
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Read with the expected byte noted first
   task automatic rdx(logic [7:0] a, e);
      expq.push_back(e);
      H.xfer(a, 8'h00, 1'b0);
   endtask
   task automatic key(logic [31:0] k);
      for (int i = 0; i < 4; i++) H.xfer(8'(8'h39 + i), k[8*i+:8], 1'b1);
   endtask
   // Result watcher
   always @(posedge i_clock) begin
      if (rvalid === 1'b1) chk("read data", expq.pop_front(), rdata);
      if (fwd === 1'b1) begin
         fwd_n++;
         chk("forward addr", fwdq.pop_front(), faddr);
         chk("forward data", fwdq.pop_front(), fdata);
      end
   end
   initial begin
      repeat (5000) @(posedge i_clock);
      bad_count++;
      print_verdict;
   end
   initial begin
      void'($urandom(38));
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      skey <= $urandom();
      rdx(8'h3D, 8'hC0);
      rdx(8'h3E, 8'h00);
      key(skey);
      for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge i_clock);
      if (n == 200) bad_count++;
      // Odd byte, so never equal to the index reset value
      d = 8'($urandom()) | 8'h01;
      H.xfer(8'h3D, d, 1'b1);
      rdx(8'h3D, 8'hC0);
      key(skey);
      H.xfer(8'h3D, d, 1'b1);
      // Write while the clock enable is low must be ignored
      ce <= 1'b0;
      H.xfer(8'h3D, ~d, 1'b1);
      ce <= 1'b1;
      rdx(8'h3D, d);
      for (int i = 0; i < 4; i++) begin
         key(skey ^ (32'h1 << (8 * i)));
         H.xfer(8'h3E, 8'(i + 1), 1'b1);
         rdx(8'h3E, 8'h00);
         rdx(8'(8'h39 + i), 8'h00);
      end
      rdx(8'h50, 8'h00);
      i_wr_guarded <= 1'b1;
      H.xfer(8'h10, d, 1'b1);
      i_wr_guarded <= 1'b0;
      fwdq.push_back(8'h11);
      fwdq.push_back(d);
      H.xfer(8'h11, d, 1'b1);
      kce <= 8'($urandom_range(254));
      H.xfer(8'h3E, d ^ 8'h5A, 1'b1);
      rdx(8'h3E, d ^ 8'h5A);
      H.xfer(8'h3D, ~d, 1'b1);
      rdx(8'h3D, ~d);
      @(posedge i_clock);
      ld <= 1'b1;
      ldd <= 8'($urandom());
      @(posedge i_clock);
      ld <= 1'b0;
      rdx(8'h3E, ldd);
      kce <= 8'hFF;
      key(skey);
      H.xfer(8'h3E, ~d, 1'b1);
      rdx(8'h3E, ~d);
      repeat (4) @(posedge i_clock);
      chk("forward count", 8'h01, 8'(fwd_n));
      chk("pending reads", 8'h00, 8'(expq.size()));
      chk("pending forwards", 8'h00, 8'(fwdq.size()));
      print_verdict;
   end
endmodule
`default_nettype wire
